// ---- core/shs_pkg.sv ----
// shared types and constants for the sync header stream framer
package shs_pkg;
   // block geometry: 2-bit header plus 64 scrambled data bits
   localparam int SH_BITS = 2;
   localparam int DATA_BITS = 64;
   localparam int BLK_BITS = SH_BITS + DATA_BITS;
   localparam int MB_BLOCKS = 32;
   localparam int E_FIXED = 1;
   // local extended multiblock period, in blocks and in serial bit periods
   localparam int LEMC_BLOCKS = MB_BLOCKS * E_FIXED;
   localparam int LEMC_BITS = BLK_BITS * LEMC_BLOCKS;
   localparam logic [4:0] LAST_BLOCK = 5'h1f;
   localparam logic [7:0] E_SUPPORTED = 8'h01;

   // header as {bit1, bit0}; bit0 goes out first
   localparam logic [1:0] SH_FOR_ONE = 2'h2;
   localparam logic [1:0] SH_FOR_ZERO = 2'h1;

   // stream layout in crc-12 mode
   localparam logic [31:0] STREAM_FIXED_ONES = 32'h80a88888;
   localparam int EOEMB_POS = 22;
   localparam int EOMB_FIRST_POS = 27;
   localparam int CRC_GROUPS = 4;
   localparam int CRC_GROUP_BITS = 3;
   localparam int CRC_GROUP_STRIDE = 4;

   // crc-12 generator, explicit x^12 dropped (0x987 in implicit-one notation)
   localparam int CRC_W = 12;
   localparam logic [11:0] CRC_POLY = 12'h30f;
   localparam logic [11:0] CRC_RESET = 12'h000;

   // self-synchronous scrambler 1 + x^39 + x^58
   localparam int SCR_W = 58;
   localparam int SCR_TAP_A = 38;
   localparam int SCR_TAP_B = 57;
   localparam logic [57:0] SCR_RESET = 58'h0;

   typedef struct packed {
      logic [65:0] blk;
      logic [4:0] idx;
      logic lemc_edge;
   } tx_out_t;

   typedef struct packed {
      logic sysref_q;
      logic [4:0] cnt;
      logic [11:0] crc;
      logic [11:0] parity;
      logic cfg_bad;
      tx_out_t out;
   } framer_state_t;

   typedef struct packed {
      logic [57:0] lfsr;
   } scr_state_t;
endpackage : shs_pkg

// ---- core/crc12_step.sv ----
// crc-12 update over one 64-bit block, first bit sent is data[63]
`timescale 1ns/100ps
module crc12_step
(
   input wire logic [11:0] crc_in,
   input wire logic [63:0] data,
   output logic [11:0] crc_out
);
   always_comb
   begin
      logic [11:0] s;
      logic fb;
      s = crc_in;
      fb = 1'b0;
      for (int i = shs_pkg::DATA_BITS - 1; i >= 0; i--)
      begin
         fb = data[i] ^ s[shs_pkg::CRC_W - 1];
         s = {s[10:0], 1'b0} ^ (fb ? shs_pkg::CRC_POLY : 12'h000); // R20
      end
      crc_out = s;
   end
endmodule : crc12_step

// ---- core/block_scrambler.sv ----
// self-synchronous scrambler for one 64-bit block per clock
`timescale 1ns/100ps
module block_scrambler
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [63:0] data,
   output logic [63:0] scr
);
   shs_pkg::scr_state_t state;
   shs_pkg::scr_state_t next_state;

   always_comb
   begin
      logic [57:0] s;
      logic b;
      s = state.lfsr;
      b = 1'b0;
      scr = 64'h0;
      // bits are scrambled in send order, msb first
      for (int i = shs_pkg::DATA_BITS - 1; i >= 0; i--)
      begin
         b = data[i] ^ s[shs_pkg::SCR_TAP_A] ^ s[shs_pkg::SCR_TAP_B]; // R1
         scr[i] = b;
         s = {s[56:0], b};
      end
      next_state.lfsr = s;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         state.lfsr <= shs_pkg::SCR_RESET;
      else
         state <= next_state;
   end
endmodule : block_scrambler

// ---- core/shs_framer.sv ----
// transmit framer: multiblocks, lemc, sync header stream with crc-12
// Function
// R1 - scramble block, prefix two-bit header
// R2 - thirty-two blocks per multiblock
// R3 - extended multiblock holds exactly one multiblock
// R4 - extended multiblock holds whole frames
// R5 - sysref resets local extended multiblock clock
// R6 - lemc period is 66*32*E bit periods
// R7 - continuous sysref divides multiblock clock
// R8 - header always 01 or 10
// R9 - receiver finds block boundary by transitions
// R10 - receiver treats 00/11 as misalignment
// R11 - header bits form 32-bit stream
// R12 - block n carries stream bit n
// R13 - stream ends with 00001
// R14 - bit 22 marks extended multiblock end
// R15 - end-of-extended bit set every multiblock
// R16 - only crc-12 stream mode generated
// R17 - parity bits in 0-2,4-6,8-10,12-14
// R18 - command bits and 27-30 are zero
// R19 - fixed ones at 3,7,11,15,19,21,23,31
// R20 - crc-12 over 2048 scrambled data bits
// R21 - crc cleared before each multiblock
// R22 - parity sent in the following multiblock
// R23 - receiver compares parity with next multiblock
// R24 - receiver detection latency at least 46 blocks
// R25 - receiver confirms pilot over several multiblocks
`timescale 1ns/100ps
module shs_framer
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sysref,
   input wire logic [63:0] data_in,
   input wire logic [7:0] emb_len_req,
   output logic [65:0] blk_out,
   output logic [4:0] blk_idx,
   output logic lemc_edge,
   output logic cfg_unsupported
);
   shs_pkg::framer_state_t state;
   shs_pkg::framer_state_t next_state;

   logic [63:0] scr;
   logic [11:0] crc_upd;
   logic [11:0] crc_base;
   logic sysref_rise;
   logic [4:0] idx;
   logic [31:0] stream;

   block_scrambler u_scr
   (
      .clk(clk),
      .rst_b(rst_b),
      .data(data_in),
      .scr(scr)
   );

   // a block that starts a multiblock always begins from a cleared crc
   assign crc_base = (idx == 5'h00) ? shs_pkg::CRC_RESET : state.crc; // R21

   crc12_step u_crc
   (
      .crc_in(crc_base),
      .data(scr),
      .crc_out(crc_upd)
   );

   // stream for the multiblock being sent, from the previous parity word
   function automatic logic [31:0] build_stream(input logic [11:0] par);
      logic [31:0] s;
      s = shs_pkg::STREAM_FIXED_ONES; // R19 R18 R13
      s[shs_pkg::EOEMB_POS] = 1'b1; // R14 R15
      for (int g = 0; g < shs_pkg::CRC_GROUPS; g++)
      begin
         for (int j = 0; j < shs_pkg::CRC_GROUP_BITS; j++)
         begin
            s[g * shs_pkg::CRC_GROUP_STRIDE + j] = par[11 - g * shs_pkg::CRC_GROUP_BITS - j]; // R17
         end
      end
      return s;
   endfunction : build_stream

   assign sysref_rise = sysref && !state.sysref_q;
   // a sysref edge forces this block to be block 0 of a new multiblock
   assign idx = sysref_rise ? 5'h00 : state.cnt; // R5
   assign stream = build_stream(state.parity); // R11 R16

   always_comb
   begin
      next_state = state;
      next_state.sysref_q = sysref;
      next_state.cnt = idx + 5'h01; // R2 R6
      next_state.crc = crc_upd; // R20
      // an interrupted multiblock keeps the old parity word
      if (idx == shs_pkg::LAST_BLOCK)
      begin
         next_state.parity = crc_upd; // R22
      end
      // only E = 1 is built; anything else is flagged, not honoured
      next_state.cfg_bad = (emb_len_req != shs_pkg::E_SUPPORTED); // R3 R4
      next_state.out.idx = idx; // R12
      next_state.out.lemc_edge = (idx == 5'h00);
      next_state.out.blk[1:0] = stream[idx] ? shs_pkg::SH_FOR_ONE : shs_pkg::SH_FOR_ZERO; // R8
      for (int i = 0; i < shs_pkg::DATA_BITS; i++)
      begin
         next_state.out.blk[shs_pkg::SH_BITS + i] = scr[shs_pkg::DATA_BITS - 1 - i]; // R1
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state.sysref_q <= 1'b0;
         state.cnt <= 5'h00;
         state.crc <= shs_pkg::CRC_RESET;
         state.parity <= shs_pkg::CRC_RESET;
         state.cfg_bad <= 1'b0;
         state.out.blk <= 66'h0;
         state.out.idx <= 5'h00;
         state.out.lemc_edge <= 1'b0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign blk_out = state.out.blk;
   assign blk_idx = state.out.idx;
   assign lemc_edge = state.out.lemc_edge;
   assign cfg_unsupported = state.cfg_bad;

   // helper: blocks since the last lemc edge, for the period check
   // a regular lemc edge reads 32 here; an edge forced by sysref is left out
   logic [7:0] gap;
   logic gap_valid;
   logic rise_d;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         gap <= 8'h00;
         gap_valid <= 1'b0;
         rise_d <= 1'b0;
      end
      else
      begin
         rise_d <= sysref_rise;
         if (lemc_edge)
         begin
            gap <= 8'h01;
            gap_valid <= !rise_d;
         end
         else if (gap != 8'hff)
         begin
            gap <= gap + 8'h01;
         end
      end
   end

   logic [1:0] sh;
   assign sh = blk_out[1:0];

   // send-order copy of the scrambled word, for the data placement check
   logic [63:0] scr_rev;
   always_comb
   begin
      for (int i = 0; i < shs_pkg::DATA_BITS; i++)
      begin
         scr_rev[i] = scr[shs_pkg::DATA_BITS - 1 - i];
      end
   end

   sequence s_sysref_edge;
      sysref && !state.sysref_q;
   endsequence

   sequence s_new_mb;
      lemc_edge && (blk_idx == 5'h00);
   endsequence

   sequence s_mb_tail;
      (blk_idx == 5'd27) ##1 (blk_idx == 5'd28) ##1 (blk_idx == 5'd29)
      ##1 (blk_idx == 5'd30) ##1 (blk_idx == shs_pkg::LAST_BLOCK);
   endsequence

   // four zero headers then a one, all inside one multiblock
   sequence s_pilot;
      ((sh == shs_pkg::SH_FOR_ZERO) && !lemc_edge)
      ##1 ((sh == shs_pkg::SH_FOR_ZERO) && !lemc_edge)
      ##1 ((sh == shs_pkg::SH_FOR_ZERO) && !lemc_edge)
      ##1 ((sh == shs_pkg::SH_FOR_ZERO) && !lemc_edge)
      ##1 ((sh == shs_pkg::SH_FOR_ONE) && !lemc_edge);
   endsequence

   a_sh_differs: assert property (@(posedge clk) disable iff (!rst_b) // R8
      $past(rst_b) |-> (sh == shs_pkg::SH_FOR_ONE || sh == shs_pkg::SH_FOR_ZERO))
      else $error("sync header bits equal");

   a_sysref_phase: assert property (@(posedge clk) disable iff (!rst_b) // R5
      s_sysref_edge |=> s_new_mb)
      else $error("sysref did not restart the multiblock");

   a_mb_wrap: assert property (@(posedge clk) disable iff (!rst_b) // R2
      (blk_idx == shs_pkg::LAST_BLOCK) ##1 !rise_d |-> s_new_mb)
      else $error("multiblock not 32 blocks");

   a_lemc_period: assert property (@(posedge clk) disable iff (!rst_b) // R6
      lemc_edge && gap_valid && !rise_d && $past(rst_b, 40) |-> (gap == 8'd32))
      else $error("lemc period wrong");

   a_lemc_gap: assert property (@(posedge clk) disable iff (!rst_b) // R6
      lemc_edge && !rise_d && $past(lemc_edge, 32) && $past(rst_b, 40)
      |-> $past(gap, 1) == 8'd31)
      else $error("lemc edges not 32 blocks apart");

   a_eomb_pilot: assert property (@(posedge clk) disable iff (!rst_b) // R13
      s_mb_tail |-> ($past(sh, 4) == shs_pkg::SH_FOR_ZERO)
      && ($past(sh, 3) == shs_pkg::SH_FOR_ZERO) && ($past(sh, 2) == shs_pkg::SH_FOR_ZERO)
      && ($past(sh, 1) == shs_pkg::SH_FOR_ZERO) && (sh == shs_pkg::SH_FOR_ONE))
      else $error("end of multiblock pilot wrong");

   a_eoemb_set: assert property (@(posedge clk) disable iff (!rst_b) // R14 R15
      $past(rst_b) && blk_idx == 5'd22 |-> sh == shs_pkg::SH_FOR_ONE)
      else $error("end of extended multiblock bit not set");

   a_fixed_ones: assert property (@(posedge clk) disable iff (!rst_b) // R19
      $past(rst_b) && blk_idx inside {5'd3, 5'd7, 5'd11, 5'd15, 5'd19, 5'd21, 5'd23}
      |-> sh == shs_pkg::SH_FOR_ONE)
      else $error("fixed one missing");

   a_cmd_zero: assert property (@(posedge clk) disable iff (!rst_b) // R18
      $past(rst_b) && blk_idx inside {5'd16, 5'd17, 5'd18, 5'd20, 5'd24, 5'd25, 5'd26}
      |-> sh == shs_pkg::SH_FOR_ZERO)
      else $error("command bit not zero");

   a_parity_next: assert property (@(posedge clk) disable iff (!rst_b) // R17 R22
      (idx == shs_pkg::LAST_BLOCK) && !sysref_rise ##1 !sysref_rise
      |=> (blk_idx == 5'h00) && (sh == (state.parity[11] ? shs_pkg::SH_FOR_ONE
      : shs_pkg::SH_FOR_ZERO)) && state.parity == $past(crc_upd, 2))
      else $error("parity not carried into next multiblock");

   a_crc_cleared: assert property (@(posedge clk) disable iff (!rst_b) // R21
      (idx == 5'h00) |-> crc_base == shs_pkg::CRC_RESET)
      else $error("crc not cleared at multiblock start");

   a_cfg_flag: assert property (@(posedge clk) disable iff (!rst_b) // R3
      (emb_len_req != shs_pkg::E_SUPPORTED) |=> cfg_unsupported)
      else $error("unsupported extended multiblock length not flagged");

   a_cfg_clear: assert property (@(posedge clk) disable iff (!rst_b) // R3
      (emb_len_req == shs_pkg::E_SUPPORTED) |=> !cfg_unsupported)
      else $error("supported extended multiblock length flagged");

   // block numbering: one step per cycle, a restart only through a lemc edge
   a_idx_step: assert property (@(posedge clk) disable iff (!rst_b) // R2 R12
      $past(rst_b) && !lemc_edge |-> blk_idx == $past(blk_idx) + 5'h01)
      else $error("block number skipped");

   a_lemc_idx: assert property (@(posedge clk) disable iff (!rst_b) // R12
      lemc_edge |-> blk_idx == 5'h00)
      else $error("lemc edge away from block 0");

   a_lemc_single: assert property (@(posedge clk) disable iff (!rst_b) // R2
      lemc_edge && !sysref_rise |=> !lemc_edge)
      else $error("lemc edge lasted two blocks");

   a_first_block: assert property (@(posedge clk) disable iff (!rst_b) // R5 R12
      !$past(rst_b) |=> s_new_mb)
      else $error("first block after reset not block 0");

   // a held sysref level must not keep restarting the multiblock
   a_sysref_level: assert property (@(posedge clk) disable iff (!rst_b) // R5
      sysref && state.sysref_q && (state.cnt != 5'h00) |=> !lemc_edge)
      else $error("sysref level restarted framing");

   a_gap_bound: assert property (@(posedge clk) disable iff (!rst_b) // R6
      gap_valid |-> gap <= 8'd32)
      else $error("lemc edge missing");

   // parity moves only when a full multiblock has been consumed
   a_parity_hold: assert property (@(posedge clk) disable iff (!rst_b) // R21 R22
      $past(rst_b) && $changed(state.parity) |-> $past(idx) == shs_pkg::LAST_BLOCK)
      else $error("parity word changed mid multiblock");

   // parity bit position worked out arithmetically, apart from build_stream
   a_parity_map: assert property (@(posedge clk) disable iff (!rst_b) // R17
      $past(rst_b) && (blk_idx < 5'd15) && (blk_idx[1:0] != 2'h3)
      |-> sh == (state.parity[4'd11 - blk_idx[3:0] + {2'h0, blk_idx[3:2]}]
      ? shs_pkg::SH_FOR_ONE : shs_pkg::SH_FOR_ZERO))
      else $error("parity bit in wrong stream position");

   a_data_order: assert property (@(posedge clk) disable iff (!rst_b) // R1
      $past(rst_b) |-> blk_out[65:2] == $past(scr_rev))
      else $error("scrambled data out of send order");

   // only the real end of a multiblock may show the pilot
   a_pilot_unique: assert property (@(posedge clk) disable iff (!rst_b) // R13 R19
      s_pilot |-> blk_idx == shs_pkg::LAST_BLOCK)
      else $error("end of multiblock pilot seen early");
endmodule : shs_framer

// ---- tb/rx_model.sv ----
// far-end receiver model: stream assembly, crc-12 of each multiblock, descrambler
`timescale 1ns/100ps
module rx_model
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [65:0] blk,
   input wire logic lemc_edge,
   output logic [31:0] word,
   output logic [11:0] prev_crc,
   output logic word_done,
   output logic [63:0] plain,
   output logic [7:0] hdr_bad
);
   logic [31:0] sh;
   logic [11:0] last;
   logic [57:0] ds;
   logic [4:0] n;
   logic [11:0] crc;
   logic sync;

   // lemc is the transmitter's own lemc_edge output, so it marks block 0
   always @(posedge clk or negedge rst_b)
   begin : rx
      logic [11:0] c;
      logic [57:0] s;
      logic [4:0] k;
      if (!rst_b)
      begin
         {sh, last, ds, n, crc, sync, word, prev_crc, word_done, plain, hdr_bad} <= '0;
      end
      else
      begin
         k = lemc_edge ? 5'h00 : n + 5'h01;
         c = lemc_edge ? 12'h000 : crc;
         s = ds;
         for (int i = 0; i < 64; i++)
         begin
            plain[63 - i] <= blk[2 + i] ^ s[38] ^ s[57];
            s = {s[56:0], blk[2 + i]};
            c = {c[10:0], 1'b0} ^ ({12{c[11] ^ blk[2 + i]}} & 12'h30f);
         end
         ds <= s;
         n <= k;
         crc <= c;
         sync <= sync | lemc_edge;
         sh[k] <= blk[1];
         // headers before the first lemc edge are reset leftovers, not traffic
         if ((sync | lemc_edge) && blk[0] == blk[1])
            hdr_bad <= hdr_bad + 8'h01;
         word_done <= k == 5'h1f;
         if (k == 5'h1f)
         begin
            word <= {blk[1], sh[30:0]};
            prev_crc <= last;
            last <= c;
         end
      end
   end
endmodule : rx_model

// ---- tb/testbench.sv ----
// self-checking bench: framer fed with blocks, receiver model judges the lane
`timescale 1ns/100ps
module testbench;
   logic clk, rst_b, sysref, lemc_edge, cfg_unsupported, word_done, ebad;
   logic [63:0] data_in, plain, d1, d2;
   logic [7:0] emb_len_req, hdr_bad;
   logic [65:0] blk_out;
   logic [4:0] blk_idx, ei;
   logic [31:0] word;
   logic [11:0] prev_crc;
   int n_mismatch = 0;
   int n_compared = 0;

   shs_framer uut (.clk(clk), .rst_b(rst_b), .sysref(sysref), .data_in(data_in),
      .emb_len_req(emb_len_req), .blk_out(blk_out), .blk_idx(blk_idx),
      .lemc_edge(lemc_edge), .cfg_unsupported(cfg_unsupported));
   rx_model far (.clk(clk), .rst_b(rst_b), .blk(blk_out), .lemc_edge(lemc_edge),
      .word(word), .prev_crc(prev_crc), .word_done(word_done), .plain(plain),
      .hdr_bad(hdr_bad));

   task automatic check(input string what, input logic [65:0] seen, input logic [65:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic give_verdict;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   function automatic logic [31:0] exp_word(input logic [11:0] p);
      logic [31:0] w;
      w = 32'h80e88888;
      for (int g = 0; g < 4; g++)
         for (int k = 0; k < 3; k++)
            w[4 * g + k] = p[11 - 3 * g - k];
      return w;
   endfunction : exp_word

   // one block per falling edge; outputs seen here were launched by the last rising edge
   task automatic step(input logic [63:0] d, input logic sr, input logic [7:0] emb);
      @(negedge clk);
      check("blk_idx", blk_idx, ei);
      check("lemc_edge", lemc_edge, ei == 5'h00);
      check("cfg_unsupported", cfg_unsupported, ebad);
      check("plain", plain, d2);
      if (word_done)
         check("stream", word, exp_word(prev_crc));
      ei = (sr && !sysref) ? 5'h00 : ei + 5'h01;
      ebad = emb != 8'h01;
      d2 = d1;
      d1 = d;
      data_in = d;
      sysref = sr;
      emb_len_req = emb;
   endtask : step

   task automatic t_reset;
      rst_b = 1'b0;
      repeat (20) @(negedge clk);
      check("blk_out", blk_out, 66'h0);
      check("lemc_edge", lemc_edge, 1'b0);
      rst_b = 1'b1;
      $display("reset test done");
   endtask : t_reset

   task automatic t_frames;
      for (int i = 0; i < 96; i++)
         step({2{32'(i) * 32'h9e3779b9}}, 1'b0, 8'h01);
      $display("framing test done");
   endtask : t_frames

   // rise mid-multiblock, then a long high level that must not restart again
   task automatic t_sysref;
      for (int i = 0; i < 80; i++)
         step({32'(i), 32'hc3a50f1e}, i >= 11 && i < 50, 8'h01);
      // continuous sysref, one pulse per multiblock on the block 0 position
      for (int i = 0; i < 96; i++)
         step({32'hc3a50f1e, 32'(i)}, ei == 5'h1f, 8'h01);
      $display("sysref test done");
   endtask : t_sysref

   task automatic t_emb;
      for (int i = 0; i < 72; i++)
         step(~{32'(i), 32'(i)}, 1'b0, (i < 36) ? 8'h02 + 8'(i % 3) * 8'h7f : 8'h01);
      $display("extended multiblock test done");
   endtask : t_emb

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial
   begin
      #(50 * 3000);
      n_mismatch++;
      give_verdict();
   end

   initial
   begin
      {rst_b, sysref, ebad, ei, d1, d2, data_in} = '0;
      emb_len_req = 8'h01;
      t_reset();
      t_frames();
      t_sysref();
      t_emb();
      check("hdr_bad", hdr_bad, 8'h00);
      give_verdict();
   end
endmodule : testbench
